// File: common/dasp_pkg.sv
// Purpose: shared constants and types of the dual converter serial port
// Assumes: 25 MHz core clock, 3-bit register address, 12-bit register data
// Notes:   register offsets, field positions and reset codes live here only
package dasp_pkg;
	localparam int unsigned CLK_MHZ      = 25;
	// conversion time of the core clock timed engine
	localparam int unsigned CONV_TIME_NS = 200;
	localparam int unsigned CONV_CYC     = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CONV_CNT_W   = 3;

	localparam int unsigned RES16_W    = 16;
	localparam int unsigned RES14_W    = 14;
	localparam int unsigned BOOST_BITS = 2;
	localparam int unsigned RES_MAX_W  = 18;
	localparam int unsigned CRC_W      = 8;
	localparam int unsigned LANE_W     = 44;
	localparam int unsigned MSG_W      = 36;
	localparam int unsigned CMD_W      = 16;
	localparam int unsigned WCRC_END   = 24;
	localparam int unsigned DATA_W     = 12;
	localparam logic [7:0]  CRC_POLY   = 8'h07;

	localparam logic [2:0] ADDR_CFG1  = 3'h1;
	localparam logic [2:0] ADDR_CFG2  = 3'h2;
	localparam logic [2:0] ADDR_ALERT = 3'h3;

	localparam int unsigned CFG1_RES_BIT    = 1;
	localparam int unsigned CFG1_REFERENCE_SOURCE_SELECT_BIT = 2;
	localparam int unsigned CFG1_CRCW_BIT   = 4;
	localparam int unsigned CFG1_CRCR_BIT   = 5;
	localparam int unsigned CFG1_OSR_LSB    = 6;
	localparam int unsigned CFG1_OSR_W      = 3;
	localparam int unsigned CFG2_LANE_BIT   = 8;
	localparam int unsigned ALERT_SETUP_BIT = 11;
	localparam int unsigned ALERT_FLAG_W    = 4;

	localparam logic [11:0] CFG1_RST       = 12'h000;
	localparam logic        CFG2_LANE_RST  = 1'b0;
	localparam logic [7:0]  RST_CODE_SOFT  = 8'h3c;
	localparam logic [7:0]  RST_CODE_HARD  = 8'hff;

	typedef enum logic [1:0] {
		FR_IDLE  = 2'b00,
		FR_SHIFT = 2'b01,
		FR_DONE  = 2'b11
	} dasp_frame_e;
endpackage

// File: logic/dasp_crc8.sv
// Purpose: checksum over a right-aligned message of variable length
// Assumes: message bits above i_len are ignored
// Notes:   the eight leading message bits are inverted before division
`timescale 1ns/10ps
module dasp_crc8 (
	input  wire logic [35:0] i_msg,
	input  wire logic [5:0]  i_len,
	output logic      [7:0]  o_crc
);
	always_comb begin
		logic [7:0] c;
		logic       b;
		c = 8'h00;
		b = 1'b0;
		// msb first division, zero seed, remainder of msg * x^8 with its top eight bits inverted
		for (int i = 35; i >= 0; i--) begin
			if (i < int'(i_len)) begin
				b = i_msg[i] ^ (i >= int'(i_len) - 8);
				if (c[7] ^ b) begin
					c = {c[6:0], 1'b0} ^ dasp_pkg::CRC_POLY;
				end else begin
					c = {c[6:0], 1'b0};
				end
			end
		end
		o_crc = c;
	end
endmodule

// File: logic/dasp_serial_port.sv
// Purpose: serial port, register set and reset control of a dual converter
// Assumes: cs, sclk and serial input come from the host's clock domain
// Notes:   sclk must stay well below a quarter of the core clock
`timescale 1ns/10ps
module dasp_serial_port (
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_cs_n,
	input  wire logic        i_sclk,
	input  wire logic        i_serial_in,
	input  wire logic        i_variant14,
	input  wire logic [17:0] i_adc_a_data,
	input  wire logic [17:0] i_adc_b_data,
	input  wire logic [3:0]  i_alert_flags,
	input  wire logic        i_selftest_fail,
	output logic             o_serial_out_first,
	output logic             o_serial_out_first_oe_n,
	output logic             o_serial_out_second,
	output logic             o_serial_out_second_oe_n,
	output logic             o_sample_start,
	output logic             o_conv_busy,
	output logic             o_ref_buf_en,
	output logic             o_soft_rst,
	output logic             o_hard_rst,
	output logic [11:0]      o_cfg_first,
	output logic             o_output_lane_mode,
	output logic             o_setup_fail
);
	typedef struct packed {
		logic                      cs_s1, cs_s2, cs_s3;
		logic                      sck_s1, sck_s2, sck_s3;
		logic                      sdi_s1, sdi_s2;
		logic                      init_done;
		logic                      variant14;
		dasp_pkg::dasp_frame_e     frame;
		logic [5:0]                bit_cnt;
		logic [5:0]                out_cnt;
		logic                      ans;
		logic [15:0]               cmd;
		logic [7:0]                crcin;
		logic [43:0]               lane_a;
		logic [17:0]               lane_b;
		logic                      sdo_a, sdo_b, oe_a_n, oe_b_n;
		logic                      rd_pend;
		logic [2:0]                rd_addr;
		logic [11:0]               cfg1;
		logic                      lane_mode;
		logic [11:0]               alert;
		logic [17:0]               res_a, res_b;
		logic                      conv_busy;
		logic [2:0]                conv_cnt;
		logic                      sample_p, soft_p, hard_p, st_pend;
	} dasp_state_s;

	dasp_state_s r;
	dasp_state_s n;

	logic        cs_fall, cs_rise, sck_rise, sck_fall, conv_done;
	logic        boost, two_wire, crc_rd_en, crc_wr_en;
	logic [4:0]  res_w;
	logic [5:0]  frame_len, tail_len;
	logic [17:0] a_l, b_l;
	logic [11:0] reg_val;
	logic [15:0] rd_word;
	logic [35:0] msg_out;
	logic [5:0]  len_out;
	logic [7:0]  crc_out, crc_wr;
	logic        is_write, need_crc, crc_ok, wr_ok, enough;
	logic [2:0]  cmd_addr;

	assign cs_fall   = r.cs_s3 & ~r.cs_s2;
	assign cs_rise   = ~r.cs_s3 & r.cs_s2;
	assign sck_rise  = ~r.sck_s3 & r.sck_s2;
	assign sck_fall  = r.sck_s3 & ~r.sck_s2;
	assign conv_done = r.conv_busy && (r.conv_cnt == '0);

	assign two_wire  = ~r.lane_mode;
	assign crc_rd_en = r.cfg1[dasp_pkg::CFG1_CRCR_BIT];
	assign crc_wr_en = r.cfg1[dasp_pkg::CFG1_CRCW_BIT];
	assign boost     = r.cfg1[dasp_pkg::CFG1_RES_BIT]
		&& (r.cfg1[dasp_pkg::CFG1_OSR_LSB +: dasp_pkg::CFG1_OSR_W] != '0);
	assign res_w     = (r.variant14 ? 5'(dasp_pkg::RES14_W) : 5'(dasp_pkg::RES16_W))
		+ (boost ? 5'(dasp_pkg::BOOST_BITS) : 5'h00);
	// informative frame length, used by the tail check below
	assign frame_len = (two_wire ? {1'b0, res_w} : {res_w, 1'b0})
		+ (crc_rd_en ? 6'(dasp_pkg::CRC_W) : 6'h00);
	// a register answer is one command word long, whatever the readout width
	assign tail_len  = r.ans ? 6'(dasp_pkg::CMD_W) + (crc_rd_en ? 6'(dasp_pkg::CRC_W) : 6'h00)
		: frame_len;
	assign a_l = r.res_a << (5'(dasp_pkg::RES_MAX_W) - res_w);
	assign b_l = r.res_b << (5'(dasp_pkg::RES_MAX_W) - res_w);

	always_comb begin
		unique case (r.rd_addr)
			dasp_pkg::ADDR_CFG1:  reg_val = r.cfg1;
			dasp_pkg::ADDR_CFG2:  reg_val = 12'({r.lane_mode, 8'h00}); // reset field reads 0
			dasp_pkg::ADDR_ALERT: reg_val = r.alert;
			default:              reg_val = 12'h000;
		endcase
	end
	assign rd_word = {1'b0, r.rd_addr, reg_val};

	// checksum over both results, or over the register word on a read answer
	assign msg_out = r.rd_pend ? {20'h00000, rd_word}
		: ((36'(r.res_a) << res_w) | 36'(r.res_b));
	assign len_out = r.rd_pend ? 6'(dasp_pkg::CMD_W) : {res_w, 1'b0};

	dasp_crc8 u_crc_out (
		.i_msg (msg_out),
		.i_len (len_out),
		.o_crc (crc_out)
	);
	dasp_crc8 u_crc_wr (
		.i_msg ({20'h00000, r.cmd}),
		.i_len (6'(dasp_pkg::CMD_W)),
		.o_crc (crc_wr)
	);

	assign cmd_addr = r.cmd[14:12];
	assign is_write = r.cmd[15];
	assign enough   = r.bit_cnt >= 6'(dasp_pkg::CMD_W);
	// turning write checksum on already needs a checksummed frame
	assign need_crc = crc_wr_en
		|| (cmd_addr == dasp_pkg::ADDR_CFG1 && r.cmd[dasp_pkg::CFG1_CRCW_BIT]);
	assign crc_ok   = (crc_wr == r.crcin) && (r.bit_cnt >= 6'(dasp_pkg::WCRC_END));
	assign wr_ok    = enough && is_write && (!need_crc || crc_ok);

	always_comb begin
		logic        do_soft;
		logic        do_hard;
		logic [3:0]  alert_set;
		logic [43:0] la;
		do_soft   = 1'b0;
		do_hard   = 1'b0;
		alert_set = 4'h0;
		la        = '0;
		n = r;
		n.cs_s1  = i_cs_n;
		n.cs_s2  = r.cs_s1;
		n.cs_s3  = r.cs_s2;
		n.sck_s1 = i_sclk;
		n.sck_s2 = r.sck_s1;
		n.sck_s3 = r.sck_s2;
		n.sdi_s1 = i_serial_in;
		n.sdi_s2 = r.sdi_s1;
		n.sample_p = 1'b0;
		n.soft_p   = 1'b0;
		n.hard_p   = 1'b0;

		// strap caught once after release; self-test result follows
		if (!r.init_done) begin
			n.init_done = 1'b1;
			n.variant14 = i_variant14;
			n.st_pend   = 1'b1;
		end
		if (r.st_pend) begin
			n.st_pend = 1'b0;
			n.alert[dasp_pkg::ALERT_SETUP_BIT] = i_selftest_fail;
		end

		// engine timed by core clock only
		if (r.conv_busy) begin
			n.conv_cnt = r.conv_cnt - 3'h1;
			if (conv_done) begin
				n.conv_busy = 1'b0;
				n.res_a     = i_adc_a_data;
				n.res_b     = i_adc_b_data;
				alert_set   = i_alert_flags;
			end
		end

		unique case (r.frame)
			dasp_pkg::FR_IDLE: begin
				if (cs_fall) begin
					n.sample_p  = 1'b1;
					n.conv_busy = 1'b1;
					n.conv_cnt  = 3'(dasp_pkg::CONV_CYC - 1);
					n.bit_cnt   = '0;
					n.frame     = dasp_pkg::FR_SHIFT;
					n.ans       = r.rd_pend;
					if (r.rd_pend) begin
						la = {rd_word, 28'h0};
						if (crc_rd_en) la = la | ({crc_out, 36'h0} >> 16);
						n.lane_b  = '0;
						n.rd_pend = 1'b0;
					end else begin
						la = {a_l, 26'h0};
						if (!two_wire) la = la | ({b_l, 26'h0} >> res_w);
						if (crc_rd_en) begin
							la = la | ({crc_out, 36'h0} >> (two_wire ? {1'b0, res_w}
								: {res_w, 1'b0}));
						end
						n.lane_b = two_wire ? b_l : 18'h00000;
					end
					// msb shows at the falling select; zeros fill the tail
					n.sdo_a  = la[43];
					n.lane_a = {la[42:0], 1'b0};
					n.sdo_b  = two_wire && !r.rd_pend && b_l[17];
					n.lane_b = {n.lane_b[16:0], 1'b0};
					n.oe_a_n = 1'b0;
					n.oe_b_n = ~two_wire;
				end
			end
			dasp_pkg::FR_SHIFT: begin
				if (sck_fall) begin
					if (r.bit_cnt < 6'(dasp_pkg::CMD_W)) begin
						n.cmd = {r.cmd[14:0], r.sdi_s2};
					end else if (r.bit_cnt < 6'(dasp_pkg::WCRC_END)) begin
						n.crcin = {r.crcin[6:0], r.sdi_s2};
					end
					if (r.bit_cnt != 6'h3f) n.bit_cnt = r.bit_cnt + 6'h01;
				end
				if (sck_rise) begin
					n.sdo_a  = r.lane_a[43];
					n.lane_a = {r.lane_a[42:0], 1'b0};
					n.sdo_b  = r.lane_b[17];
					n.lane_b = {r.lane_b[16:0], 1'b0};
				end
				if (cs_rise) begin
					n.oe_a_n = 1'b1;
					n.oe_b_n = 1'b1;
					n.sdo_a  = 1'b0;
					n.sdo_b  = 1'b0;
					n.frame  = dasp_pkg::FR_DONE;
				end
			end
			dasp_pkg::FR_DONE: begin
				n.frame = dasp_pkg::FR_IDLE;
				if (enough && !is_write) begin
					n.rd_pend = 1'b1;
					n.rd_addr = cmd_addr;
				end
				if (wr_ok) begin
					if (cmd_addr == dasp_pkg::ADDR_CFG1) n.cfg1 = r.cmd[11:0];
					if (cmd_addr == dasp_pkg::ADDR_CFG2) begin
						n.lane_mode = r.cmd[dasp_pkg::CFG2_LANE_BIT];
						if (r.cmd[7:0] == dasp_pkg::RST_CODE_HARD) do_hard = 1'b1;
						else if (r.cmd[7:0] == dasp_pkg::RST_CODE_SOFT) do_soft = 1'b1;
					end
				end
			end
			default: n.frame = dasp_pkg::FR_IDLE;
		endcase

		if (do_soft || do_hard) begin
			n.soft_p  = 1'b1;
			n.rd_pend = 1'b0;
			n.alert   = '0;
		end
		if (do_hard) begin
			n.hard_p    = 1'b1;
			n.cfg1      = dasp_pkg::CFG1_RST;
			n.lane_mode = dasp_pkg::CFG2_LANE_RST;
			n.conv_busy = 1'b0;
			n.st_pend   = 1'b1;
		end
		// output bit counter, feeds only the tail check
		if (r.frame == dasp_pkg::FR_IDLE) n.out_cnt = '0;
		else if (sck_rise && r.out_cnt != 6'h3f) n.out_cnt = r.out_cnt + 6'h01;
		// a flag raised in the clearing cycle survives
		n.alert[3:0] = n.alert[3:0] | alert_set;
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			r        <= '0;
			r.cs_s1  <= 1'b1;
			r.cs_s2  <= 1'b1;
			r.cs_s3  <= 1'b1;
			// serial clock idles high, so no false edge follows release
			r.sck_s1 <= 1'b1;
			r.sck_s2 <= 1'b1;
			r.sck_s3 <= 1'b1;
			r.oe_a_n <= 1'b1;
			r.oe_b_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign o_serial_out_first       = r.sdo_a;
	assign o_serial_out_first_oe_n  = r.oe_a_n;
	assign o_serial_out_second      = r.sdo_b;
	assign o_serial_out_second_oe_n = r.oe_b_n;
	assign o_sample_start           = r.sample_p;
	assign o_conv_busy              = r.conv_busy;
	assign o_ref_buf_en             = ~r.cfg1[dasp_pkg::CFG1_REFERENCE_SOURCE_SELECT_BIT];
	assign o_soft_rst               = r.soft_p;
	assign o_hard_rst               = r.hard_p;
	assign o_cfg_first              = r.cfg1;
	assign o_output_lane_mode       = r.lane_mode;
	assign o_setup_fail             = r.alert[dasp_pkg::ALERT_SETUP_BIT];

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	a_fall_starts: assert property (r.frame == dasp_pkg::FR_IDLE && cs_fall |=>
		o_sample_start && !o_serial_out_first_oe_n && o_conv_busy)
		else $error("select fall did not start conversion and drive output");
	a_rise_releases: assert property (r.frame == dasp_pkg::FR_SHIFT && cs_rise |=>
		o_serial_out_first_oe_n && o_serial_out_second_oe_n)
		else $error("outputs not released after select rise");
	a_conv_time: assert property ($rose(o_conv_busy) |-> o_conv_busy [*5] ##1
		(!o_conv_busy || o_sample_start))
		else $error("conversion time wrong");
	a_result_latch: assert property (conv_done && !o_hard_rst |=>
		r.res_a == $past(i_adc_a_data) && r.res_b == $past(i_adc_b_data))
		else $error("result not latched at conversion end");
	a_shift_rise: assert property (r.frame == dasp_pkg::FR_SHIFT && sck_rise && !cs_rise |=>
		o_serial_out_first == $past(r.lane_a[43]))
		else $error("first output did not shift on rising clock");
	a_one_wire: assert property (!two_wire && r.frame == dasp_pkg::FR_SHIFT |->
		o_serial_out_second_oe_n)
		else $error("second output driven in one-lane mode");
	a_hard_defaults: assert property (o_hard_rst |-> o_soft_rst
		&& o_cfg_first == dasp_pkg::CFG1_RST && !o_output_lane_mode)
		else $error("hard reset left registers changed");
	a_bad_crc_drop: assert property (r.frame == dasp_pkg::FR_DONE && is_write && need_crc
		&& !crc_ok |=> $stable(o_cfg_first) && $stable(o_output_lane_mode))
		else $error("write without valid checksum took effect");
	a_write_store: assert property (r.frame == dasp_pkg::FR_DONE && wr_ok
		&& cmd_addr == dasp_pkg::ADDR_CFG1 |=> o_cfg_first == $past(r.cmd[11:0]))
		else $error("write data not stored");
	a_read_holds: assert property (r.frame == dasp_pkg::FR_DONE && enough && !is_write
		|=> $stable(o_cfg_first) && r.rd_pend)
		else $error("read command changed registers or lost answer");
	a_tail_low: assert property (r.frame == dasp_pkg::FR_SHIFT
		&& r.out_cnt >= tail_len |-> !o_serial_out_first)
		else $error("first output not low past valid bits");
	a_ref_buffer: assert property ($rose(o_cfg_first[dasp_pkg::CFG1_REFERENCE_SOURCE_SELECT_BIT]) |->
		!o_ref_buf_en)
		else $error("reference buffer still enabled");

	c_one_wire_read: cover property (!two_wire && r.frame == dasp_pkg::FR_SHIFT && sck_rise);
	c_crc_write: cover property (r.frame == dasp_pkg::FR_DONE && wr_ok && need_crc);
	c_hard_reset: cover property (o_hard_rst);
	c_reg_read: cover property (r.rd_pend && cs_fall);
endmodule

// File: dv/dasp_host_model.sv
// Purpose: host controller for select, serial clock and command bits
// Assumes: serial clock idles high and stands still between frames
// Notes:   output bits are captured late in each low phase, where settled
`timescale 1ns/10ps
module dasp_host_model (
	input  wire logic i_core_clk,
	input  wire logic i_sdo_a,
	input  wire logic i_sdo_b,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_serial_in
);
	logic [47:0] rx_a;
	logic [47:0] rx_b;
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b1;
		o_serial_in = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask
	// cmd is left aligned: 16-bit word, then checksum byte
	task automatic frame(input logic [23:0] cmd, input int nclk);
		o_cs_n = 1'b0;
		hold(8);
		for (int k = 0; k < nclk; k++) begin
			o_serial_in = (k < 24) ? cmd[23-k] : 1'b0;
			hold(4);
			o_sclk = 1'b0;
			hold(4);
			rx_a[47-k] = i_sdo_a;
			rx_b[47-k] = i_sdo_b;
			if (k < nclk - 1)
				o_sclk = 1'b1;
		end
		o_cs_n = 1'b1;
		hold(4);
		o_sclk = 1'b1;
		// released line must not keep a stale level
		o_serial_in = ~o_serial_in;
		hold(12);
	endtask
endmodule

// File: dv/dasp_serial_port_bench.sv
// Purpose: self-checking bench of the dual converter serial port
// Assumes: 16-bit strap first, 14-bit strap after a second reset
// Notes:   expected frames come from a bit-level model in this file
`timescale 1ns/10ps
module dasp_serial_port_bench;
	logic        i_core_clk;
	logic        i_arst_n;
	logic        i_cs_n;
	logic        i_sclk;
	logic        i_serial_in;
	logic [17:0] i_adc_a_data;
	logic [17:0] i_adc_b_data;
	logic        i_selftest_fail;
	logic [3:0]  i_alert_flags;
	logic        i_variant14;
	logic        sdo_a;
	logic        sdo_a_oe_n;
	logic        sdo_b;
	logic        sdo_b_oe_n;
	logic        sample_start;
	logic        conv_busy;
	logic        ref_buf_en;
	logic        soft_rst;
	logic        hard_rst;
	logic [11:0] cfg_first;
	logic        lane_mode;
	logic        setup_fail;
	wire         wire_a;
	wire         wire_b;
	int          n_soft;
	int          n_hard;
	int          n_start;
	int          n_frames;
	int          miscompares;
	int          n_checks;
	always #20 i_core_clk = ~i_core_clk;
	assign wire_a = sdo_a_oe_n ? 1'bz : sdo_a;
	assign wire_b = sdo_b_oe_n ? 1'bz : sdo_b;
	always @(negedge i_core_clk) begin
		if (soft_rst === 1'b1) n_soft++;
		if (hard_rst === 1'b1) n_hard++;
		if (sample_start === 1'b1) n_start++;
	end
	dasp_serial_port dasp_serial_port_i (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_cs_n(i_cs_n),
		.i_sclk(i_sclk), .i_serial_in(i_serial_in), .i_variant14(i_variant14),
		.i_adc_a_data(i_adc_a_data), .i_adc_b_data(i_adc_b_data),
		.i_alert_flags(i_alert_flags), .i_selftest_fail(i_selftest_fail),
		.o_serial_out_first(sdo_a), .o_serial_out_first_oe_n(sdo_a_oe_n),
		.o_serial_out_second(sdo_b), .o_serial_out_second_oe_n(sdo_b_oe_n),
		.o_sample_start(sample_start), .o_conv_busy(conv_busy),
		.o_ref_buf_en(ref_buf_en), .o_soft_rst(soft_rst), .o_hard_rst(hard_rst),
		.o_cfg_first(cfg_first), .o_output_lane_mode(lane_mode),
		.o_setup_fail(setup_fail));
	dasp_host_model dasp_host_model_i (
		.i_core_clk(i_core_clk), .i_sdo_a(wire_a), .i_sdo_b(wire_b),
		.o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_serial_in(i_serial_in));
	task automatic chk_bits(input logic [47:0] act, input logic [47:0] exp);
		n_checks++;
		if (act !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp);
		end
	endtask
	task automatic chk_val(input logic [11:0] act, input logic [11:0] exp);
		chk_bits({36'h0, act}, {36'h0, exp});
	endtask
	task automatic complete_run();
		$display("n_checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [7:0] crc8(input logic [35:0] m, input int len);
		logic [7:0] c;
		logic       b;
		c = 8'h00;
		for (int i = len - 1; i >= 0; i--) begin
			b = m[i] ^ (i >= len - 8) ^ c[7];
			c = {c[6:0], 1'b0} ^ (b ? 8'h07 : 8'h00);
		end
		return c;
	endfunction
	task automatic xfer(input logic [15:0] w, input int n, input logic [7:0] c = 8'h00);
		dasp_host_model_i.frame({w, c}, n);
		n_frames++;
	endtask
	task automatic wr(input logic [2:0] a, input logic [11:0] d);
		xfer({1'b1, a, d}, 16);
	endtask
	// 0x8000 writes the unmapped address, used as a no-operation
	task automatic readout(input logic [17:0] a, input logic [17:0] b, input int w,
		input bit one, input bit crc);
		logic [47:0] e;
		int          p;
		int          k;
		i_adc_a_data = a;
		i_adc_b_data = b;
		xfer(16'h8000, 48);
		// newer samples must not reach the next frame
		i_adc_a_data = ~a;
		i_adc_b_data = ~b;
		for (k = 0; k < 20 && conv_busy !== 1'b0; k++)
			@(negedge i_core_clk);
		chk_val(12'(conv_busy), 12'h000);
		xfer(16'h8000, 48);
		e = 48'(a) << (48 - w);
		p = 48 - w;
		if (one) begin
			e = e | (48'(b) << (p - w));
			p = p - w;
		end
		if (crc)
			e = e | (48'(crc8((36'(a) << w) | 36'(b), 2 * w)) << (p - 8));
		chk_bits(dasp_host_model_i.rx_a, e);
		e = one ? {48{1'bz}} : 48'(b) << (48 - w);
		chk_bits(dasp_host_model_i.rx_b, e);
	endtask
	initial begin
		#4000000;
		miscompares++;
		complete_run();
	end
	initial begin
		logic [17:0] mask;
		logic [15:0] cw;
		int          w;
		i_core_clk = 1'b0;
		i_arst_n = 1'b0;
		i_adc_a_data = 18'h0;
		i_adc_b_data = 18'h0;
		i_selftest_fail = 1'b1;
		i_alert_flags = 4'h0;
		i_variant14 = 1'b0;
		void'($urandom(32'h4447));
		repeat (6) @(negedge i_core_clk);
		i_arst_n = 1'b1;
		repeat (4) @(negedge i_core_clk);
		chk_val(cfg_first, 12'h000);
		chk_val(12'({ref_buf_en, setup_fail, lane_mode}), 12'h006);
		i_selftest_fail = 1'b0;
		wr(3'h2, 12'h0ff);
		chk_val(12'({setup_fail, n_hard[3:0], n_soft[3:0]}), 12'h011);
		wr(3'h1, 12'h004);
		chk_bits(48'({ref_buf_en, cfg_first}), 48'h0004);
		i_alert_flags = 4'h5;
		xfer(16'h8000, 16);
		i_alert_flags = 4'h0;
		xfer(16'h3000, 16);
		xfer(16'h8000, 48);
		chk_bits(dasp_host_model_i.rx_a, {16'h3005, 32'h0});
		wr(3'h2, 12'h03c);
		chk_val(12'({n_hard[3:0], n_soft[3:0]}), 12'h012);
		chk_val(cfg_first, 12'h004);
		xfer(16'h3000, 16);
		xfer(16'h8000, 48);
		chk_bits(dasp_host_model_i.rx_a, {16'h3000, 32'h0});
		wr(3'h2, 12'h055);
		chk_val(12'({n_hard[3:0], n_soft[3:0]}), 12'h012);
		wr(3'h2, 12'h0ff);
		chk_bits(48'({ref_buf_en, cfg_first}), 48'h1000);
		chk_val(12'({n_hard[3:0], n_soft[3:0]}), 12'h023);
		wr(3'h1, 12'h042);
		xfer(16'h1fff, 16);
		xfer(16'h8000, 48);
		chk_bits(dasp_host_model_i.rx_a, {16'h1042, 32'h0});
		for (int c = 0; c < 8; c++) begin
			w = c[1] ? 18 : 16;
			wr(3'h1, {3'h0, 3'h1, c[0], 3'h0, c[1], 1'b0});
			wr(3'h2, {3'h0, c[2], 8'h00});
			chk_val(12'(lane_mode), 12'(c[2]));
			mask = 18'((1 << w) - 1);
			readout(18'($urandom) & mask, 18'($urandom) & mask, w, c[2], c[0]);
		end
		wr(3'h1, 12'h072);
		chk_val(cfg_first, 12'h062);
		cw = 16'h9072;
		xfer(cw, 24, crc8(36'(cw), 16));
		chk_val(cfg_first, 12'h072);
		wr(3'h1, 12'h000);
		chk_val(cfg_first, 12'h072);
		cw = 16'ha0ff;
		xfer(cw, 24, crc8(36'(cw), 16));
		chk_val(cfg_first, 12'h000);
		chk_val(12'(n_start), 12'(n_frames));
		// second reset with the narrow strap, two-lane readouts only
		i_arst_n = 1'b0;
		i_variant14 = 1'b1;
		repeat (6) @(negedge i_core_clk);
		i_arst_n = 1'b1;
		repeat (4) @(negedge i_core_clk);
		chk_val(12'({ref_buf_en, setup_fail, lane_mode}), 12'h004);
		for (int c = 0; c < 4; c++) begin
			w = c[1] ? 16 : 14;
			wr(3'h1, {3'h0, 3'h1, c[0], 3'h0, c[1], 1'b0});
			mask = 18'((1 << w) - 1);
			readout(18'($urandom) & mask, 18'($urandom) & mask, w, 1'b0, c[0]);
		end
		complete_run();
	end
endmodule
